// ==== hw/eag_palette_mem.sv ====
// sixteen-entry palette store, six colour bits each
// one write port, two read ports whose data come out of registers
`timescale 1ns/10ps
`default_nettype none
module eag_palette_mem (
  input  wire logic       clk,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_addr,
  input  wire logic [5:0] wr_data,
  input  wire logic [3:0] host_addr,
  output logic      [5:0] host_data,
  input  wire logic [3:0] pix_addr,
  output logic      [5:0] pix_data
);
  logic [5:0] mem [16];

  // contents have no reset; software loads the palette before display
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    host_data <= mem[host_addr];
    pix_data  <= mem[pix_addr];
  end
endmodule
`default_nettype wire

// ==== hw/eag_pkg.sv ====
// constants for the ega attribute and graphics register bank
// assumes one 10 MHz clock and synchronous host i/o strobes
package eag_pkg;
  // i/o port addresses
  localparam logic [15:0] PORT_ATTR_WR   = 16'h03C0;
  localparam logic [15:0] PORT_ATTR_RD   = 16'h03C1;
  localparam logic [15:0] PORT_STATUS0   = 16'h03C2;
  localparam logic [15:0] PORT_GFX_INDEX = 16'h03CE;
  localparam logic [15:0] PORT_GFX_DATA  = 16'h03CF;
  localparam logic [15:0] PORT_STAT1_MON = 16'h03BA;
  localparam logic [15:0] PORT_STAT1_COL = 16'h03DA;
  // attribute indices
  localparam logic [4:0] IDX_PALETTE_LAST  = 5'h0F;
  localparam logic [4:0] IDX_ATTR_MODE     = 5'h10;
  localparam logic [4:0] IDX_BORDER        = 5'h11;
  localparam logic [4:0] IDX_PLANE_ENABLE  = 5'h12;
  localparam logic [4:0] IDX_PIXEL_SHIFT   = 5'h13;
  // graphics indices
  localparam logic [3:0] IDX_GFX_MODE      = 4'h5;
  // field masks and fixed bits
  localparam logic [7:0] MASK_COLOR6       = 8'h3F;
  localparam logic [7:0] MASK_LOW4         = 8'h0F;
  localparam logic [7:0] MASK_GFX_MODE     = 8'h3F;
  localparam logic [3:0] STATUS0_LOW_ONES  = 4'hF;
  localparam int         STAT_SENSE_BIT    = 4;
  // write mode codes
  localparam logic [1:0] WMODE_0           = 2'h0;
  localparam logic [1:0] WMODE_1           = 2'h1;
  localparam logic [1:0] WMODE_2           = 2'h2;
  localparam logic [1:0] WMODE_ILLEGAL     = 2'h3;
  // largest pixel shifts
  localparam logic [3:0] SHIFT_MAX_NINE    = 4'h9;
  localparam logic [3:0] SHIFT_MAX_OTHER   = 4'h8;
  // reset values
  localparam logic [7:0] RST_REG8          = 8'h00;
  localparam logic [5:0] RST_COLOR         = 6'h00;
  localparam logic [4:0] RST_INDEX         = 5'h00;
  localparam logic [3:0] RST_INDEX4        = 4'h0;
endpackage

// ==== hw/eag_regs.sv ====
// ega attribute, graphics write mode and status register bank
// host strobes are one-cycle pulses synchronous to clk; pixel_en is a
// one-cycle enable from the pixel clock divider
//
// Summary of operation
// - write mode code 00, 01, 10 selects write mode 0, 1, 2
// - illegal write mode code 11 acts as write mode 1
// - sixteen palette entries at attribute indices 00 to 0F
// - palette low six bits drive the six colour lines directly
// - border register low six bits give the border colour
// - plane enable bits 5:4 steer two colour lines to status1
// - pixel shift low four bits set the left shift in pixels
// - shift limit is 9 in nine-dot mono text, else 8
// - attribute mode bits 7:4 do nothing; bits 3:0 kept
// - monitor sense result reads at status port 3C2 bit 4
// - each dac channel takes a six-bit level 0 to 63
// - status bit 4 may return stored switch info when enabled
`timescale 1ns/10ps
`default_nettype none
module eag_regs (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  input  wire logic        pixel_en,
  input  wire logic        pixel_active,
  input  wire logic [3:0]  pixel_index,
  input  wire logic        nine_dot_mono,
  input  wire logic        monitor_sense_result,
  input  wire logic        switch_sel_en,
  input  wire logic        switch_info_store,
  input  wire logic        crt_irq_pending,
  input  wire logic        vretrace,
  input  wire logic        display_disable,
  input  wire logic        pen_switch_open,
  input  wire logic        pen_trigger_set,
  input  wire logic [5:0]  dac_code_red,
  input  wire logic [5:0]  dac_code_green,
  input  wire logic [5:0]  dac_code_blue,
  output logic      [5:0]  dac_level_red,
  output logic      [5:0]  dac_level_green,
  output logic      [5:0]  dac_level_blue,
  output logic      [5:0]  video_color_line,
  output logic      [1:0]  write_mode,
  output logic      [3:0]  pixel_shift,
  output logic      [3:0]  attr_mode_bits
);
  logic       attr_ff_reg;
  logic [4:0] attr_index_reg;
  logic [3:0] gfx_index_reg;
  logic [7:0] gfx_mode_reg;
  logic [3:0] attr_mode_reg;
  logic [5:0] border_reg;
  logic [7:0] plane_en_reg;
  logic [3:0] shift_reg;
  logic       rd_pend_reg;
  logic [15:0] rd_addr_reg;
  logic       active_d_reg;
  logic       pix_step_reg;
  logic [5:0] host_pal;
  logic [5:0] pix_pal;

  // address decode
  wire wr_attr   = io_wr && (io_addr == eag_pkg::PORT_ATTR_WR);
  wire wr_attr_d = wr_attr && attr_ff_reg;
  wire wr_gfx_i  = io_wr && (io_addr == eag_pkg::PORT_GFX_INDEX);
  wire wr_gfx_d  = io_wr && (io_addr == eag_pkg::PORT_GFX_DATA);
  wire rd_stat1  = io_rd && ((io_addr == eag_pkg::PORT_STAT1_MON) ||
                             (io_addr == eag_pkg::PORT_STAT1_COL));
  wire idx_pal   = (attr_index_reg <= eag_pkg::IDX_PALETTE_LAST);
  wire wr_pal    = wr_attr_d && idx_pal;

  // colour plane enable masks the pixel index before palette lookup
  wire [3:0] pix_addr = pixel_index & plane_en_reg[3:0];

  eag_palette_mem u_pal (
    .clk       (clk),
    .wr_en     (wr_pal),
    .wr_addr   (attr_index_reg[3:0]),
    .wr_data   (io_wdata[5:0]),
    .host_addr (attr_index_reg[3:0]),
    .host_data (host_pal),
    .pix_addr  (pix_addr),
    .pix_data  (pix_pal)
  );

  // index/data flip-flop: a status1 read rearms it to index
  wire attr_ff_next = rd_stat1 ? 1'b0 : (wr_attr ? ~attr_ff_reg : attr_ff_reg);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      attr_ff_reg    <= 1'b0;
      attr_index_reg <= eag_pkg::RST_INDEX;
      gfx_index_reg  <= eag_pkg::RST_INDEX4;
    end else begin
      attr_ff_reg <= attr_ff_next;
      if (wr_attr && !attr_ff_reg) begin
        attr_index_reg <= io_wdata[4:0];
      end
      if (wr_gfx_i) begin
        gfx_index_reg <= io_wdata[3:0];
      end
    end
  end

  // register writes; unused bits are dropped, except plane enable, which stores all eight
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gfx_mode_reg  <= eag_pkg::RST_REG8;
      attr_mode_reg <= eag_pkg::RST_INDEX4;
      border_reg    <= eag_pkg::RST_COLOR;
      plane_en_reg  <= eag_pkg::RST_REG8;
      shift_reg     <= eag_pkg::RST_INDEX4;
    end else begin
      if (wr_gfx_d && (gfx_index_reg == eag_pkg::IDX_GFX_MODE)) begin
        gfx_mode_reg <= io_wdata & eag_pkg::MASK_GFX_MODE;
      end
      if (wr_attr_d && (attr_index_reg == eag_pkg::IDX_ATTR_MODE)) begin
        attr_mode_reg <= io_wdata[3:0];
      end
      if (wr_attr_d && (attr_index_reg == eag_pkg::IDX_BORDER)) begin
        border_reg <= io_wdata[5:0];
      end
      if (wr_attr_d && (attr_index_reg == eag_pkg::IDX_PLANE_ENABLE)) begin
        plane_en_reg <= io_wdata;
      end
      if (wr_attr_d && (attr_index_reg == eag_pkg::IDX_PIXEL_SHIFT)) begin
        shift_reg <= io_wdata[3:0];
      end
    end
  end

  // effective write mode: code 11 folds onto mode 1
  wire [1:0] wmode_code = gfx_mode_reg[1:0];
  wire [1:0] wmode_next = (wmode_code == eag_pkg::WMODE_ILLEGAL) ?
                          eag_pkg::WMODE_1 : wmode_code;

  // shift limit depends on the nine-dot monochrome text mode
  wire [3:0] shift_max  = nine_dot_mono ? eag_pkg::SHIFT_MAX_NINE :
                                          eag_pkg::SHIFT_MAX_OTHER;
  wire [3:0] shift_next = (shift_reg > shift_max) ? shift_max :
                                                    shift_reg;

  // colour lines: palette during active video, border otherwise;
  // the palette read takes one clock, so the active flag is delayed
  wire [5:0] color_next = active_d_reg ? pix_pal : border_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      active_d_reg     <= 1'b0;
      pix_step_reg     <= 1'b0;
      video_color_line <= eag_pkg::RST_COLOR;
      write_mode       <= eag_pkg::WMODE_0;
      pixel_shift      <= eag_pkg::RST_INDEX4;
      attr_mode_bits   <= eag_pkg::RST_INDEX4;
      dac_level_red    <= eag_pkg::RST_COLOR;
      dac_level_green  <= eag_pkg::RST_COLOR;
      dac_level_blue   <= eag_pkg::RST_COLOR;
    end else begin
      pix_step_reg <= pixel_en;
      if (pixel_en) begin
        active_d_reg <= pixel_active;
      end
      if (pix_step_reg) begin
        video_color_line <= color_next;
      end
      write_mode      <= wmode_next;
      pixel_shift     <= shift_next;
      attr_mode_bits  <= attr_mode_reg;
      dac_level_red   <= dac_code_red;
      dac_level_green <= dac_code_green;
      dac_level_blue  <= dac_code_blue;
    end
  end

  // video status multiplexer onto status1 bits 5:4
  logic [1:0] stat_mux;
  always_comb begin
    stat_mux = {video_color_line[2], video_color_line[0]};
    case (plane_en_reg[5:4])
      2'h0:    stat_mux = {video_color_line[2], video_color_line[0]};
      2'h1:    stat_mux = {video_color_line[5], video_color_line[4]};
      2'h2:    stat_mux = {video_color_line[3], video_color_line[1]};
      2'h3:    stat_mux = {video_color_line[5], video_color_line[4]};
      default: stat_mux = {video_color_line[2], video_color_line[0]};
    endcase
  end

  // monitor sense is passed as is; its meaning outside active video is
  // undefined, so software must time its read
  wire sense_bit = switch_sel_en ? switch_info_store :
                                   monitor_sense_result;
  wire [7:0] status0 = {crt_irq_pending, 2'b00, sense_bit,
                        eag_pkg::STATUS0_LOW_ONES};
  wire [7:0] status1 = {1'b0, 1'b1, stat_mux, vretrace,
                        pen_switch_open, pen_trigger_set, display_disable};

  // attribute readback by index; unmapped indices read zero
  logic [7:0] attr_rd;
  always_comb begin
    attr_rd = eag_pkg::RST_REG8;
    if (idx_pal) begin
      attr_rd = {2'b00, host_pal};
    end else begin
      case (attr_index_reg)
        eag_pkg::IDX_ATTR_MODE:    attr_rd = {4'h0, attr_mode_reg};
        eag_pkg::IDX_BORDER:       attr_rd = {2'b00, border_reg};
        eag_pkg::IDX_PLANE_ENABLE: attr_rd = plane_en_reg;
        eag_pkg::IDX_PIXEL_SHIFT:  attr_rd = {4'h0, shift_reg};
        default:                   attr_rd = eag_pkg::RST_REG8;
      endcase
    end
  end

  wire sel_gfx_mode = (gfx_index_reg == eag_pkg::IDX_GFX_MODE);
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = eag_pkg::RST_REG8;
    case (rd_addr_reg)
      eag_pkg::PORT_ATTR_WR:   rd_mux = {3'b000, attr_index_reg};
      eag_pkg::PORT_ATTR_RD:   rd_mux = attr_rd;
      eag_pkg::PORT_STATUS0:   rd_mux = status0;
      eag_pkg::PORT_GFX_INDEX: rd_mux = {4'h0, gfx_index_reg};
      eag_pkg::PORT_GFX_DATA:  rd_mux = sel_gfx_mode ? gfx_mode_reg :
                                                       eag_pkg::RST_REG8;
      eag_pkg::PORT_STAT1_MON: rd_mux = status1;
      eag_pkg::PORT_STAT1_COL: rd_mux = status1;
      default:                 rd_mux = eag_pkg::RST_REG8;
    endcase
  end

  // two-cycle read keeps the palette memory's registered output usable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 16'h0000;
      io_rdata    <= eag_pkg::RST_REG8;
      io_rvalid   <= 1'b0;
    end else begin
      rd_pend_reg <= io_rd;
      if (io_rd) begin
        rd_addr_reg <= io_addr;
      end
      io_rvalid <= rd_pend_reg;
      if (rd_pend_reg) begin
        io_rdata <= rd_mux;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/eag_host_model.sv ====
// host cpu model issuing indexed i/o port strobes
// assumes the bank answers a read with io_rvalid within eight clocks
`timescale 1ns/10ps
`default_nettype none
module eag_host_model #(
  parameter int GAP = 6
) (
  input  wire logic        clk,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rvalid
);
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // released lines show the inverse so a stale value cannot pass
  task automatic xfer(input logic [15:0] a, input logic w,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= w;
    io_rd <= !w;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    q = 8'h00;
    ok = w;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (io_rvalid === 1'b1) begin
        q = io_rdata;
        ok = 1'b1;
      end
    end
    // pixel clock is clk/2, so six clocks give three pixel clocks
    repeat (GAP) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/eag_regs_sva.sv ====
// port checker for the ega register bank
// assumes one clock, sync active-low reset, one-cycle host strobes
`timescale 1ns/10ps
`default_nettype none
module eag_regs_sva (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic        pixel_en,
  input wire logic        nine_dot_mono,
  input wire logic        monitor_sense_result,
  input wire logic        switch_sel_en,
  input wire logic        switch_info_store,
  input wire logic [5:0]  dac_code_red,
  input wire logic [5:0]  dac_level_red,
  input wire logic [5:0]  video_color_line,
  input wire logic [1:0]  write_mode,
  input wire logic [3:0]  pixel_shift
);
  logic [3:0] gidx_reg;
  logic       pixel_shift_ok;
  logic [1:0] wexp;
  logic       sense;
  logic       st0_rd;
  logic       gfx_wr;
  assign wexp = (io_wdata[1:0] == eag_pkg::WMODE_ILLEGAL) ?
                eag_pkg::WMODE_1 : io_wdata[1:0];
  assign sense = switch_sel_en ? switch_info_store : monitor_sense_result;
  // after three clocks outside nine-dot mono text the shift may not pass eight
  assign pixel_shift_ok = (pixel_shift <= eag_pkg::SHIFT_MAX_OTHER);
  assign st0_rd = io_rd && (io_addr == eag_pkg::PORT_STATUS0);
  assign gfx_wr = io_wr && (io_addr == eag_pkg::PORT_GFX_DATA) &&
                  (gidx_reg == eag_pkg::IDX_GFX_MODE);
  // index shadow so that only mode register writes are judged
  always_ff @(posedge clk) begin
    if (!rstn) gidx_reg <= eag_pkg::RST_INDEX4;
    else if (io_wr && io_addr == eag_pkg::PORT_GFX_INDEX)
      gidx_reg <= io_wdata[3:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wmode_update_a: assert property (
    gfx_wr |-> ##2 write_mode == $past(wexp, 2))
    else $error("write mode not taken from mode register");
  wmode_legal_a: assert property (
    write_mode != eag_pkg::WMODE_ILLEGAL)
    else $error("illegal write mode shown");
  shift_limit_a: assert property (
    (!nine_dot_mono)[*3] |-> pixel_shift_ok)
    else $error("pixel shift above eight");
  read_pace_a: assert property (
    io_rvalid == $past(io_rd, 2))
    else $error("read answer not two clocks after request");
  sense_bit_a: assert property (
    st0_rd |-> ##2 io_rdata[eag_pkg::STAT_SENSE_BIT] == $past(sense))
    else $error("status bit 4 does not show sense");
  status_fixed_a: assert property (
    st0_rd |-> ##2 io_rdata[6:5] == 2'h0 && io_rdata[3:0] == 4'hF)
    else $error("status fixed bits wrong");
  video_pace_a: assert property (
    $changed(video_color_line) |-> $past(pixel_en, 2))
    else $error("colour lines moved without a pixel");
  dac_level_a: assert property (
    dac_level_red == $past(dac_code_red))
    else $error("dac level not one clock behind code");
  rd_c: cover property (st0_rd);
  wmode3_c: cover property (gfx_wr && io_wdata[1:0] == 2'h3);
  line_c: cover property ($changed(video_color_line));
endmodule
bind eag_regs eag_regs_sva eag_regs_sva_i (.clk, .rstn, .io_addr, .io_wr,
  .io_rd, .io_wdata, .io_rdata, .io_rvalid, .pixel_en, .nine_dot_mono,
  .monitor_sense_result, .switch_sel_en, .switch_info_store, .dac_code_red,
  .dac_level_red, .video_color_line, .write_mode, .pixel_shift);
`default_nettype wire

// ==== tb/eag_regs_tb.sv ====
// self-checking bench for the ega register bank
// assumes eag_host_model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module eag_regs_tb;
  logic clk = 1'b0, rstn = 1'b0, pixel_en = 1'b0, pixel_active = 1'b0;
  logic nine_dot_mono = 1'b0, monitor_sense_result = 1'b0;
  logic switch_sel_en = 1'b0, crt_irq_pending = 1'b0;
  logic switch_info_store = 1'b0;
  logic [3:0] pixel_index = 4'h0;
  logic [5:0] dac_code_red = 6'h00, dac_code_blue = 6'h00;
  logic [15:0] io_addr;
  logic io_wr, io_rd, io_rvalid;
  logic [7:0] io_wdata, io_rdata, q;
  logic [5:0] dac_level_red, dac_level_green, dac_level_blue;
  logic [5:0] video_color_line;
  logic [1:0] write_mode;
  logic [3:0] pixel_shift, attr_mode_bits;
  logic [1:0] mux_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  int err_count = 0, checks_done = 0;
  always #50 clk = ~clk;
  always @(posedge clk) pixel_en <= ~pixel_en;
  eag_host_model eag_host_model_i (.clk, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .io_rvalid);
  eag_regs eag_regs_i (.clk, .rstn, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata, .io_rvalid, .pixel_en, .pixel_active, .pixel_index,
    .nine_dot_mono, .monitor_sense_result, .switch_sel_en,
    .switch_info_store, .crt_irq_pending, .vretrace(1'b1),
    .display_disable(1'b0), .pen_switch_open(1'b0), .pen_trigger_set(1'b1),
    .dac_code_red, .dac_code_green(6'h15), .dac_code_blue, .dac_level_red,
    .dac_level_green, .dac_level_blue, .video_color_line, .write_mode,
    .pixel_shift, .attr_mode_bits);
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic ok;
    eag_host_model_i.xfer(a, 1'b1, d, r, ok);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] r);
    logic ok;
    eag_host_model_i.xfer(a, 1'b0, 8'h00, r, ok);
    if (ok !== 1'b1) chk("read answer", 8'h01, 8'h00);
  endtask
  // a status1 read first puts the port flip-flop back to index state
  task automatic attr_wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] r;
    rd(eag_pkg::PORT_STAT1_COL, r);
    wr(eag_pkg::PORT_ATTR_WR, {3'h0, i});
    wr(eag_pkg::PORT_ATTR_WR, d);
  endtask
  task automatic attr_rd(input logic [4:0] i, output logic [7:0] r);
    rd(eag_pkg::PORT_STAT1_COL, r);
    wr(eag_pkg::PORT_ATTR_WR, {3'h0, i});
    rd(eag_pkg::PORT_ATTR_RD, r);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(eag_pkg::PORT_GFX_INDEX, 8'h05);
      wr(eag_pkg::PORT_GFX_DATA, 8'hC0 | m[7:0]);
      chk("write_mode", (m == 3) ? 8'h01 : m[7:0], {6'h0, write_mode});
      rd(eag_pkg::PORT_GFX_DATA, q);
      chk("mode reg", m[7:0], q);
    end
    for (int i = 0; i < 16; i++) attr_wr(i[4:0], 8'hC0 | (i[7:0] << 2));
    for (int i = 0; i < 16; i++) begin
      attr_rd(i[4:0], q);
      chk("palette", i[7:0] << 2, q);
    end
    attr_rd(5'h14, q);
    chk("unmapped index", 8'h00, q);
    attr_wr(eag_pkg::IDX_BORDER, 8'hEA);
    attr_wr(eag_pkg::IDX_PLANE_ENABLE, 8'h0F);
    attr_rd(eag_pkg::IDX_BORDER, q);
    chk("border", 8'h2A, q);
    chk("border line", 8'h2A, {2'h0, video_color_line});
    pixel_index <= 4'h6;
    pixel_active <= 1'b1;
    repeat (4) @(posedge clk);
    chk("palette line", 8'h18, {2'h0, video_color_line});
    for (int s = 0; s < 4; s++) begin
      attr_wr(eag_pkg::IDX_PLANE_ENABLE, {2'h0, s[1:0], 4'hF});
      rd(eag_pkg::PORT_STAT1_COL, q);
      chk("status mux", {2'h1, mux_exp[s], 4'hA}, q);
    end
    nine_dot_mono <= 1'b1;
    attr_wr(eag_pkg::IDX_PIXEL_SHIFT, 8'hFF);
    attr_rd(eag_pkg::IDX_PIXEL_SHIFT, q);
    chk("shift reg", 8'h0F, q);
    chk("shift nine", 8'h09, {4'h0, pixel_shift});
    nine_dot_mono <= 1'b0;
    attr_rd(eag_pkg::IDX_PIXEL_SHIFT, q);
    chk("shift other", 8'h08, {4'h0, pixel_shift});
    attr_wr(eag_pkg::IDX_PIXEL_SHIFT, 8'h05);
    chk("shift plain", 8'h05, {4'h0, pixel_shift});
    attr_wr(eag_pkg::IDX_ATTR_MODE, 8'hA5);
    attr_rd(eag_pkg::IDX_ATTR_MODE, q);
    chk("attr mode", 8'h05, q);
    chk("attr bits", 8'h05, {4'h0, attr_mode_bits});
    monitor_sense_result <= 1'b1;
    rd(eag_pkg::PORT_STATUS0, q);
    chk("sense", 8'h1F, q);
    switch_sel_en <= 1'b1;
    crt_irq_pending <= 1'b1;
    rd(eag_pkg::PORT_STATUS0, q);
    chk("switch info", 8'h8F, q);
    switch_info_store <= 1'b1;
    monitor_sense_result <= 1'b0;
    rd(eag_pkg::PORT_STATUS0, q);
    chk("switch info set", 8'h9F, q);
    dac_code_red <= 6'h3F;
    dac_code_blue <= 6'h2A;
    repeat (2) @(posedge clk);
    chk("dac red", 8'h3F, {2'h0, dac_level_red});
    chk("dac blue", 8'h2A, {2'h0, dac_level_blue});
    chk("dac green", 8'h15, {2'h0, dac_level_green});
    attr_wr(eag_pkg::IDX_BORDER, 8'h00);
    rd(16'h0300, q);
    chk("unmapped port", 8'h00, q);
    stop_test;
  end
endmodule
`default_nettype wire
